// [rtl/dwk_port.sv]
// Top of the 16-line digital I/O port with change, match and strobe
// interrupts and wake routing, reached through byte-wide host I/O.
// Assumes single-cycle read and write strobes and synchronous decode.
//
// Notes on behaviour
// - Each port 0 bit has own direction; inputs read pin, outputs last write.
// - Port 0 data write drives every output-configured port 0 pin.
// - Port 1 has one direction; input reads pins, output drives and reads back.
// - Control bits 1:0 map shared window to clear, direction, mask or compare.
// - Reading the clear function drops any pending interrupt request.
// - Writing clear zeroes compare, mask, control and both data registers.
// - Direction bit zero makes pin input, one makes it output.
// - Mask bit one excludes that bit from comparison and change detection.
// - All mask bits set disables the comparator; no change or match events.
// - Match mode compares unmasked compare bits against current port 0.
// - Match or change sets control bit 6 and raises interrupt if enabled.
// - Mode field bits 4:3: 10 change, 11 match, 01 strobe.
// - Change and match modes sample port 0 at 8.33 MHz.
// - Deglitching guarantees detection of levels lasting 120 ns or more outside standby.
// - Strobe rising edge raises request, held until clear is read or written.
// - Strobe edge captures port 0 into compare; next strobe waits for read.
// - Wake bit 0 lets events wake; wake bit 1 masks interrupt only.
// - Strobe, match and change events can all produce a wake.
// - In standby sampling runs at 32 kHz instead of normal rate.
// - Change mode interrupts when any unmasked port 0 bit changes.
// - Match mode interrupts when all unmasked bits equal the pattern.
// - Control and data registers reset to zero, lines become inputs.
`timescale 1ns/1ps
module dwk_port
  import dwk_pkg::*;
#(
  parameter int STBY_DIVIDER = STBY_DIV
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] io_addr_in,
  input  wire logic              io_wr_in,
  input  wire logic              io_rd_in,
  input  wire logic [7:0]        io_wdata_in,
  output logic      [7:0]        io_rdata_out,
  input  wire logic [7:0]        bit_port_line_in,
  output logic      [7:0]        bit_port_line_out,
  output logic      [7:0]        bit_port_line_oe_n_out,
  input  wire logic [7:0]        byte_port_line_in,
  output logic      [7:0]        byte_port_line_out,
  output logic      [7:0]        byte_port_line_oe_n_out,
  input  wire logic              strobe_in,
  input  wire logic              standby_in,
  output logic                   irq_out,
  output logic                   wake_out
);
  logic [7:0]  port0_data;
  logic [7:0]  port1_data;
  logic [7:0]  port0_direction;
  logic [7:0]  compare_mask;
  logic [7:0]  pattern_compare;
  logic [7:0]  port_control;
  logic [7:0]  wake_control;
  logic        irq_pending;
  logic        match_seen;
  dwk_strobe_e strobe_state;

  logic [7:0]  p0_sync;
  logic        strobe_sync;
  logic        strobe_prev;
  logic        tick;
  logic [7:0]  p0_sample;

  logic        wr_p0, wr_p1, wr_win, wr_ctl, wr_wake, rd_win;
  logic        clear_write, clear_read, cmp_write, cmp_read;
  logic [1:0]  sel;
  logic [1:0]  mode;
  logic        cmp_on, change_hit, match_now, match_evt;
  logic        strobe_rise, strobe_evt, event_any;
  logic [7:0]  next_rdata;

  dwk_sync #(.W(9)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({strobe_in, bit_port_line_in}),
    .q_out  ({strobe_sync, p0_sync})
  );

  dwk_sampler #(.NDIV(NORM_DIV), .SDIV(STBY_DIVIDER)) u_sampler (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .standby_in (standby_in),
    .d_in       (p0_sync),
    .tick_out   (tick),
    .sample_out (p0_sample)
  );

  assign sel         = port_control[CTL_SEL_HI:CTL_SEL_LO];
  assign mode        = port_control[CTL_MODE_HI:CTL_MODE_LO];
  assign wr_p0       = io_wr_in && io_addr_in == OFF_PORT0;
  assign wr_p1       = io_wr_in && io_addr_in == OFF_PORT1;
  assign wr_win      = io_wr_in && io_addr_in == OFF_WINDOW;
  assign wr_ctl      = io_wr_in && io_addr_in == OFF_CONTROL;
  assign wr_wake     = io_wr_in && io_addr_in == OFF_WAKE;
  assign rd_win      = io_rd_in && io_addr_in == OFF_WINDOW;
  assign clear_write = wr_win && sel == SEL_CLEAR;
  assign clear_read  = rd_win && sel == SEL_CLEAR;
  assign cmp_write   = wr_win && sel == SEL_COMPARE;
  assign cmp_read    = rd_win && sel == SEL_COMPARE;

  // Detection. All-ones mask turns the comparator off entirely.
  assign cmp_on      = compare_mask != 8'hFF;
  assign change_hit  = tick && cmp_on && mode == MODE_CHANGE &&
                       |((p0_sample ^ pattern_compare) & ~compare_mask);
  assign match_now   = cmp_on && mode == MODE_MATCH &&
                       ((p0_sample ^ pattern_compare) & ~compare_mask) == 8'h00;
  // Only the entry into a match counts, so a held match fires once.
  assign match_evt   = match_now && !match_seen;
  assign strobe_rise = strobe_sync && !strobe_prev;
  assign strobe_evt  = strobe_rise && mode == MODE_STROBE &&
                       strobe_state == DWK_ARMED;
  assign event_any   = change_hit || match_evt || strobe_evt;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_prev <= 1'b0;
      match_seen  <= 1'b0;
    end else begin
      strobe_prev <= strobe_sync;
      match_seen  <= match_now;
    end
  end

  // Data registers and their clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port0_data <= RST_BYTE;
      port1_data <= RST_BYTE;
    end else if (clear_write) begin
      port0_data <= RST_BYTE;
      port1_data <= RST_BYTE;
    end else begin
      if (wr_p0) begin
        port0_data <= io_wdata_in;
      end
      if (wr_p1) begin
        port1_data <= io_wdata_in;
      end
    end
  end

  // Shared window targets other than compare.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port0_direction <= RST_BYTE;
      compare_mask    <= RST_BYTE;
    end else if (clear_write) begin
      compare_mask <= RST_BYTE;
    end else if (wr_win && sel == SEL_DIR) begin
      port0_direction <= io_wdata_in;
    end else if (wr_win && sel == SEL_MASK) begin
      compare_mask <= io_wdata_in;
    end
  end

  // Compare register: host write, change-mode sampling, strobe capture.
  // Match mode leaves it alone so the pattern survives.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pattern_compare <= RST_BYTE;
    end else if (clear_write) begin
      pattern_compare <= RST_BYTE;
    end else if (strobe_evt) begin
      pattern_compare <= p0_sync;
    end else if (cmp_write) begin
      pattern_compare <= io_wdata_in;
    end else if (tick && mode == MODE_CHANGE) begin
      pattern_compare <= p0_sample;
    end
  end

  // Control register; bit 6 is the event flag, a set beats any clear.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      port_control <= RST_BYTE;
    end else begin
      if (clear_write) begin
        port_control <= RST_BYTE;
      end else if (wr_ctl) begin
        port_control[CTL_MODE_HI:CTL_SEL_LO] <=
          io_wdata_in[CTL_MODE_HI:CTL_SEL_LO];
      end
      if (change_hit || match_evt) begin
        port_control[CTL_FLAG] <= 1'b1;
      end else if (clear_read) begin
        port_control[CTL_FLAG] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake_control <= RST_BYTE;
    end else if (wr_wake) begin
      wake_control <= {6'h00, io_wdata_in[INT_MASK_BIT:WAKE_EN_BIT]};
    end
  end

  // Pending request: events set it, a clear read drops it.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_pending <= 1'b0;
    end else if (event_any) begin
      irq_pending <= 1'b1;
    end else if (clear_read || clear_write) begin
      irq_pending <= 1'b0;
    end
  end

  // Strobe arming: one capture per compare read.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobe_state <= DWK_ARMED;
    end else begin
      case (strobe_state)
        DWK_ARMED: begin
          if (strobe_evt) begin
            strobe_state <= DWK_HELD;
          end
        end
        DWK_HELD: begin
          if (cmp_read || clear_write) begin
            strobe_state <= DWK_ARMED;
          end
        end
        default: begin
          strobe_state <= DWK_ARMED;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_out  <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      irq_out  <= irq_pending && !wake_control[INT_MASK_BIT];
      wake_out <= irq_pending && wake_control[WAKE_EN_BIT];
    end
  end

  // Pins: open enable is low while driving.
  assign bit_port_line_out       = port0_data;
  assign bit_port_line_oe_n_out  = ~port0_direction;
  assign byte_port_line_out      = port1_data;
  assign byte_port_line_oe_n_out = {8{~port_control[CTL_P1_DIR]}};

  always_comb begin
    next_rdata = 8'h00;
    case (io_addr_in)
      OFF_PORT0: begin
        next_rdata = (port0_direction & port0_data) |
                     (~port0_direction & p0_sync);
      end
      OFF_PORT1: begin
        next_rdata = port_control[CTL_P1_DIR] ? port1_data
                                              : byte_port_line_in;
      end
      OFF_WINDOW: begin
        case (sel)
          SEL_DIR:     next_rdata = port0_direction;
          SEL_MASK:    next_rdata = compare_mask;
          SEL_COMPARE: next_rdata = pattern_compare;
          default:     next_rdata = 8'h00;
        endcase
      end
      OFF_CONTROL: begin
        next_rdata = {1'b0, port_control[CTL_FLAG], 1'b0,
                      port_control[CTL_MODE_HI:CTL_SEL_LO]};
      end
      OFF_WAKE: begin
        next_rdata = wake_control;
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      io_rdata_out <= 8'h00;
    end else if (io_rd_in) begin
      io_rdata_out <= next_rdata;
    end
  end

  sequence s_strobe_taken;
    strobe_evt ##1 strobe_state == DWK_HELD;
  endsequence

  a_clear_read_drops: assert property (@(posedge clk_in) disable iff (rst_in)
    clear_read && !event_any |=> !irq_pending)
    else $error("Pending request survived a clear read.");
  a_clear_write_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    clear_write |=> port0_data == 8'h00 && port1_data == 8'h00 &&
                    compare_mask == 8'h00 && pattern_compare == 8'h00)
    else $error("Clear write left a register nonzero.");
  a_dir_drives_pin: assert property (@(posedge clk_in) disable iff (rst_in)
    bit_port_line_oe_n_out == ~port0_direction)
    else $error("Pin enable does not follow direction.");
  a_mask_all_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
    compare_mask == 8'hFF |-> !change_hit && !match_evt)
    else $error("Event raised with all bits masked.");
  a_flag_on_event: assert property (@(posedge clk_in) disable iff (rst_in)
    change_hit || match_evt |=> port_control[CTL_FLAG])
    else $error("Event flag not set after event.");
  a_strobe_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    s_strobe_taken |-> irq_pending && $past(p0_sync) == pattern_compare)
    else $error("Strobe capture or request missing.");
  a_strobe_ignored: assert property (@(posedge clk_in) disable iff (rst_in)
    strobe_state == DWK_HELD && !cmp_read && !clear_write
      |=> $stable(pattern_compare) || $past(cmp_write) ||
          $past(tick && mode == MODE_CHANGE))
    else $error("Compare changed by a held strobe.");
  a_wake_routing: assert property (@(posedge clk_in) disable iff (rst_in)
    irq_pending ##1 irq_pending |->
      wake_out == $past(wake_control[WAKE_EN_BIT]) &&
      irq_out == !$past(wake_control[INT_MASK_BIT]))
    else $error("Wake or interrupt routing wrong.");
  a_port1_readback: assert property (@(posedge clk_in) disable iff (rst_in)
    io_rd_in && io_addr_in == OFF_PORT1 && port_control[CTL_P1_DIR]
      |=> io_rdata_out == $past(port1_data))
    else $error("Port 1 output readback wrong.");
endmodule : dwk_port

// [rtl/dwk_pkg.sv]
// Shared constants for the digital I/O port with wake and interrupt logic.
// Assumes a byte-wide host I/O access port and a 250 MHz core clock.
package dwk_pkg;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFF_PORT0     = 12'h450;
  localparam logic [11:0] OFF_PORT1     = 12'h451;
  localparam logic [11:0] OFF_WINDOW    = 12'h452;
  localparam logic [11:0] OFF_CONTROL   = 12'h453;
  localparam logic [11:0] OFF_WAKE      = 12'h454;

  localparam logic [7:0]  RST_BYTE      = 8'h00;

  // Control register fields.
  localparam int          CTL_SEL_LO    = 0;
  localparam int          CTL_SEL_HI    = 1;
  localparam int          CTL_P1_DIR    = 2;
  localparam int          CTL_MODE_LO   = 3;
  localparam int          CTL_MODE_HI   = 4;
  localparam int          CTL_FLAG      = 6;
  // Wake control fields.
  localparam int          WAKE_EN_BIT   = 0;
  localparam int          INT_MASK_BIT  = 1;

  localparam logic [1:0]  SEL_CLEAR     = 2'h0;
  localparam logic [1:0]  SEL_DIR       = 2'h1;
  localparam logic [1:0]  SEL_MASK      = 2'h2;
  localparam logic [1:0]  SEL_COMPARE   = 2'h3;

  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_STROBE   = 2'h1;
  localparam logic [1:0]  MODE_CHANGE   = 2'h2;
  localparam logic [1:0]  MODE_MATCH    = 2'h3;

  // Timing: core clock and the two sampling rates, in kHz.
  localparam int          CLK_RATE_KHZ  = 250000;
  localparam int          NORM_RATE_KHZ = 8330;
  localparam int          STBY_RATE_KHZ = 32;
  localparam int          NORM_DIV      = CLK_RATE_KHZ / NORM_RATE_KHZ;
  localparam int          STBY_DIV      = CLK_RATE_KHZ / STBY_RATE_KHZ;
  // Shortest level guaranteed to be seen, in ns; one sample period.
  localparam int          DEGLITCH_NS   = 120;

  typedef enum logic [2:0] {
    DWK_ARMED = 3'b001,
    DWK_HELD  = 3'b010,
    DWK_IDLE  = 3'b100
  } dwk_strobe_e;
endpackage : dwk_pkg

// [rtl/dwk_sync.sv]
// Two-flop synchroniser for a bundle of asynchronous levels.
// Assumes each bit is an independent level; no bus coherence is given.
`timescale 1ns/1ps
module dwk_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end
endmodule : dwk_sync

// [rtl/dwk_sampler.sv]
// Sampling tick generator and deglitched port sample register.
// Assumes d_in is already synchronised to clk_in.
`timescale 1ns/1ps
module dwk_sampler
  import dwk_pkg::*;
#(
  parameter int NDIV = NORM_DIV,
  parameter int SDIV = STBY_DIV
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       standby_in,
  input  wire logic [7:0] d_in,
  output logic            tick_out,
  output logic      [7:0] sample_out
);
  logic [15:0] cnt;
  logic [15:0] limit;
  logic [15:0] half;
  logic        half_tick;
  logic [7:0]  prev;

  // Standby swaps the slow divider in so sampling ticks at the low rate off clk_in.
  assign limit = standby_in ? 16'(SDIV - 1) : 16'(NDIV - 1);
  assign half  = limit >> 1;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt       <= '0;
      tick_out  <= 1'b0;
      half_tick <= 1'b0;
    end else begin
      tick_out  <= (cnt >= limit);
      half_tick <= (cnt == half);
      cnt       <= (cnt >= limit) ? '0 : cnt + 16'h0001;
    end
  end

  // Samples are taken twice per period and a bit is accepted only when two
  // successive samples agree: a level held one full period always spans two
  // of them, while a half-period glitch passes only if it straddles a pair.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prev       <= '0;
      sample_out <= '0;
    end else if (tick_out || half_tick) begin
      prev <= d_in;
      for (int i = 0; i < 8; i++) begin
        if (prev[i] == d_in[i]) begin
          sample_out[i] <= d_in[i];
        end
      end
    end
  end
endmodule : dwk_sampler

// [tb/dwk_lines.sv]
// Connector model for the two byte ports of the digital I/O block.
// Assumes the far side drives every line the block leaves released.
`timescale 1ns/1ps
module dwk_lines (
  input  wire logic [7:0] p0_out_in,
  input  wire logic [7:0] p0_oe_n_in,
  input  wire logic [7:0] p0_ext_in,
  input  wire logic [7:0] p1_out_in,
  input  wire logic [7:0] p1_oe_n_in,
  input  wire logic [7:0] p1_ext_in,
  output logic      [7:0] p0_pin_out,
  output logic      [7:0] p1_pin_out
);
  // Each wire carries the block's drive where enabled, else the connector.
  assign p0_pin_out = (p0_oe_n_in & p0_ext_in) | (~p0_oe_n_in & p0_out_in);
  assign p1_pin_out = (p1_oe_n_in & p1_ext_in) | (~p1_oe_n_in & p1_out_in);
endmodule : dwk_lines

// [tb/tb_dwk_port.sv]
// Self-checking bench for the digital I/O port, driven through host I/O.
// Assumes the connector model resolves both byte ports.
`timescale 1ns/1ps
module tb_dwk_port
  import dwk_pkg::*;
;
  logic              clk_in, rst_in, io_wr_in, io_rd_in, strobe_in;
  logic              standby_in, irq_out, wake_out;
  logic [ADDR_W-1:0] io_addr_in;
  logic [7:0]        io_wdata_in, io_rdata_out, ext0, ext1, d;
  logic [7:0]        p0_out, p0_oe_n, p0_pin, p1_out, p1_oe_n, p1_pin;
  int                n_fail, n_checks;
  int                cyc = 0;

  dwk_port #(.STBY_DIVIDER(8)) u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in),
    .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in),
    .io_rdata_out(io_rdata_out), .bit_port_line_in(p0_pin),
    .bit_port_line_out(p0_out), .bit_port_line_oe_n_out(p0_oe_n),
    .byte_port_line_in(p1_pin), .byte_port_line_out(p1_out),
    .byte_port_line_oe_n_out(p1_oe_n), .strobe_in(strobe_in),
    .standby_in(standby_in), .irq_out(irq_out), .wake_out(wake_out));

  dwk_lines u_lines (
    .p0_out_in(p0_out), .p0_oe_n_in(p0_oe_n), .p0_ext_in(ext0),
    .p1_out_in(p1_out), .p1_oe_n_in(p1_oe_n), .p1_ext_in(ext1),
    .p0_pin_out(p0_pin), .p1_pin_out(p1_pin));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic summarize;
    if (n_fail == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize

  // A hung wait must still end in the single verdict.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clk_in);
    io_addr_in  <= a;
    io_wdata_in <= v;
    io_wr_in    <= 1'b1;
    @(posedge clk_in);
    io_wr_in    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [7:0] v);
    @(posedge clk_in);
    io_addr_in <= a;
    io_rd_in   <= 1'b1;
    @(posedge clk_in);
    io_rd_in   <= 1'b0;
    #1 v = io_rdata_out;
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : idle

  // Waits a bounded time for irq_out or wake_out to rise, then checks it.
  task automatic wait_ev(input bit use_wake, input int max);
    int i;
    for (i = 0; i < max; i++) begin
      @(posedge clk_in);
      #1;
      if ((use_wake ? wake_out : irq_out) === 1'b1) break;
    end
    chk({7'h00, use_wake ? wake_out : irq_out}, 8'h01);
  endtask : wait_ev

  function automatic logic [7:0] ctl(logic [1:0] m, logic p1, logic [1:0] s);
    return {3'b000, m, p1, s};
  endfunction : ctl

  // Connector and strobe changes land on a rising edge, like the bus.
  task automatic set_ext0(input logic [7:0] v);
    @(posedge clk_in);
    ext0 <= v;
  endtask : set_ext0

  task automatic set_ext1(input logic [7:0] v);
    @(posedge clk_in);
    ext1 <= v;
  endtask : set_ext1

  task automatic set_strb(input logic v);
    @(posedge clk_in);
    strobe_in <= v;
  endtask : set_strb

  initial begin
    n_fail = 0; n_checks = 0;
    rst_in = 1'b1; io_wr_in = 1'b0; io_rd_in = 1'b0; io_addr_in = '0;
    io_wdata_in = 8'h00; strobe_in = 1'b0; standby_in = 1'b0;
    ext0 = 8'h96; ext1 = 8'h00;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    idle(3);
    chk(p0_oe_n, 8'hFF);
    chk(p1_oe_n, 8'hFF);
    rd(OFF_CONTROL, d); chk(d, 8'h00);
    rd(OFF_WAKE, d); chk(d, 8'h00);
    rd(OFF_PORT0, d); chk(d, 8'h96);
    wr(OFF_CONTROL, ctl(MODE_OFF, 1'b0, SEL_DIR));
    wr(OFF_WINDOW, 8'h0F);
    wr(OFF_PORT0, 8'hA5);
    idle(1);
    chk(p0_oe_n, 8'hF0);
    chk(p0_out, 8'hA5);
    rd(OFF_PORT0, d); chk(d, 8'h95);
    rd(OFF_WINDOW, d); chk(d, 8'h0F);
    wr(OFF_CONTROL, ctl(MODE_OFF, 1'b1, SEL_DIR));
    wr(OFF_PORT1, 8'h3C);
    idle(1);
    chk(p1_oe_n, 8'h00);
    rd(OFF_PORT1, d); chk(d, 8'h3C);
    wr(OFF_CONTROL, ctl(MODE_OFF, 1'b0, SEL_CLEAR));
    set_ext1(8'hC3);
    rd(OFF_PORT1, d); chk(d, 8'hC3);
    wr(12'h455, 8'hFF);
    rd(12'h455, d); chk(d, 8'h00);
    wr(OFF_WINDOW, 8'h00);
    idle(1);
    chk(p0_out, 8'h00);
    chk(p1_out, 8'h00);
    rd(OFF_CONTROL, d); chk(d, 8'h00);
    wr(OFF_CONTROL, ctl(MODE_OFF, 1'b0, SEL_DIR));
    wr(OFF_WINDOW, 8'h00);
    wr(OFF_CONTROL, ctl(MODE_OFF, 1'b0, SEL_MASK));
    wr(OFF_WINDOW, 8'hFE);
    wr(OFF_CONTROL, ctl(MODE_CHANGE, 1'b0, SEL_CLEAR));
    idle(200);
    rd(OFF_WINDOW, d);
    set_ext0(8'h94);
    idle(200);
    chk({7'h00, irq_out}, 8'h00);
    // A level held exactly one sample period must still be caught.
    set_ext0(8'h95);
    idle(29);
    set_ext0(8'h94);
    wait_ev(1'b0, 300);
    idle(100);
    rd(OFF_CONTROL, d); chk(d, 8'h50);
    rd(OFF_WINDOW, d);
    idle(2);
    chk({7'h00, irq_out}, 8'h00);
    wr(OFF_CONTROL, ctl(MODE_CHANGE, 1'b0, SEL_MASK));
    wr(OFF_WINDOW, 8'hFF);
    wr(OFF_CONTROL, ctl(MODE_CHANGE, 1'b0, SEL_CLEAR));
    rd(OFF_WINDOW, d);
    set_ext0(8'h6A);
    idle(300);
    chk({7'h00, irq_out}, 8'h00);
    set_ext0(8'h05);
    wr(OFF_CONTROL, ctl(MODE_MATCH, 1'b0, SEL_MASK));
    wr(OFF_WINDOW, 8'h0F);
    wr(OFF_CONTROL, ctl(MODE_MATCH, 1'b0, SEL_COMPARE));
    wr(OFF_WINDOW, 8'h5A);
    wr(OFF_CONTROL, ctl(MODE_MATCH, 1'b0, SEL_CLEAR));
    rd(OFF_WINDOW, d);
    idle(200);
    chk({7'h00, irq_out}, 8'h00);
    set_ext0(8'h53);
    wait_ev(1'b0, 300);
    wr(OFF_CONTROL, ctl(MODE_STROBE, 1'b0, SEL_CLEAR));
    rd(OFF_WINDOW, d);
    set_ext0(8'h77);
    idle(4);
    set_strb(1'b1);
    wait_ev(1'b0, 20);
    set_strb(1'b0);
    set_ext0(8'h11);
    idle(6);
    set_strb(1'b1);
    idle(10);
    set_strb(1'b0);
    wr(OFF_CONTROL, ctl(MODE_STROBE, 1'b0, SEL_COMPARE));
    rd(OFF_WINDOW, d); chk(d, 8'h77);
    chk({7'h00, irq_out}, 8'h01);
    wr(OFF_CONTROL, ctl(MODE_STROBE, 1'b0, SEL_CLEAR));
    rd(OFF_WINDOW, d);
    idle(2);
    chk({7'h00, irq_out}, 8'h00);
    wr(OFF_WAKE, 8'h01);
    set_strb(1'b1);
    wait_ev(1'b1, 20);
    chk({7'h00, irq_out}, 8'h01);
    wr(OFF_WAKE, 8'h03);
    idle(2);
    chk({7'h00, irq_out}, 8'h00);
    chk({7'h00, wake_out}, 8'h01);
    set_strb(1'b0);
    standby_in <= 1'b1;
    wr(OFF_CONTROL, ctl(MODE_CHANGE, 1'b0, SEL_MASK));
    wr(OFF_WINDOW, 8'h00);
    wr(OFF_CONTROL, ctl(MODE_CHANGE, 1'b0, SEL_CLEAR));
    idle(60);
    rd(OFF_WINDOW, d);
    idle(2);
    chk({7'h00, wake_out}, 8'h00);
    set_ext0(8'h01);
    wait_ev(1'b1, 60);
    summarize();
  end
endmodule : tb_dwk_port
